// ===== logic/cpu_address_mode_unit.sv
`timescale 1ns/1ps
module cpu_address_mode_unit (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire addr_mode_pkg::addr_mode_e mode,
    input wire logic [7:0] op_lo,
    input wire logic [7:0] op_hi,
    input wire logic [7:0] idx_x,
    input wire logic [7:0] idx_y,
    input wire logic [7:0] stack_ptr,
    input wire logic [7:0] pc_low_byte,
    input wire logic [7:0] pc_high_byte,
    input wire logic branch_taken,
    input wire logic rmw,
    input wire logic store_accumulator,
    input wire logic [7:0] mem_rdata,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic busy,
    output logic done,
    output logic [15:0] eff_addr,
    output logic [15:0] next_pc,
    output logic [3:0] cycles,
    output logic [1:0] length
);
    import addr_mode_pkg::*;

    typedef enum logic [1:0] {IDLE, PTR_LO, PTR_HI} walk_e;
    walk_e state;
    addr_mode_e mode_q;
    logic [7:0] ptr_loc;
    logic [7:0] ptr_low;
    logic [15:0] ptr_full;
    logic [15:0] ptr_sum;
    logic needs_ptr;
    logic zp_ptr;
    logic ptr_crossed;
    logic [15:0] seq_pc;
    mode_req_if req ();

    // a start refused during a walk must not steer the count of the running one
    assign req.mode = (state == IDLE) ? mode : mode_q;
    assign req.op_lo = op_lo;
    assign req.op_hi = op_hi;
    assign req.idx_x = idx_x;
    assign req.idx_y = idx_y;
    assign req.pc = {pc_high_byte, pc_low_byte};
    assign req.branch_taken = branch_taken;
    assign req.rmw = rmw;
    assign req.store_acc = store_accumulator;

    addr_calc u_calc (
        .req(req)
    );

    cycle_count u_count (
        .req(req),
        .ptr_crossed(ptr_crossed)
    );

    // modes that read a two byte pointer before the operand address is known
    assign needs_ptr = (mode == MODE_ZP_X_IND) || (mode == MODE_ZP_IND) ||
        (mode == MODE_ZP_IND_Y) || (mode == MODE_ABS_IND) || (mode == MODE_ABS_IDX_IND);
    assign zp_ptr = (mode_q == MODE_ZP_X_IND) || (mode_q == MODE_ZP_IND) ||
        (mode_q == MODE_ZP_IND_Y);
    assign ptr_full = {mem_rdata, ptr_low};
    assign ptr_sum = ptr_full + {8'h00, idx_y};
    assign ptr_crossed = page_crossed(ptr_full, ptr_sum);
    assign seq_pc = req.pc + {14'h0000, req.length};

    // pointer fetch sequencer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= IDLE;
            mode_q <= MODE_IMPL;
            ptr_loc <= 8'h00;
        end else begin
            unique case (state)
                IDLE: if (start) begin
                    mode_q <= mode;
                    if (needs_ptr) begin
                        state <= PTR_LO;
                        ptr_loc <= req.eff_addr[7:0];
                    end
                end
                PTR_LO: state <= PTR_HI;
                PTR_HI: state <= IDLE;
            endcase
        end
    end

    // low pointer byte capture
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            ptr_low <= 8'h00;
        else if (state == PTR_LO)
            ptr_low <= mem_rdata;
    end

    // pointer address: zero page pointers wrap in page zero, absolute ones use eff_addr
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_addr <= RESET_ADDR;
            mem_rd <= 1'b0;
        end else if (state == IDLE && start && needs_ptr) begin
            mem_addr <= req.eff_addr; // low byte of pointer
            mem_rd <= 1'b1;
        end else if (state == PTR_LO) begin
            if (zp_ptr)
                mem_addr <= {ZERO_PAGE, 8'(ptr_loc + 8'h01)};
            else
                mem_addr <= 16'(mem_addr + 16'h0001);
            mem_rd <= 1'b1;
        end else begin
            mem_rd <= 1'b0;
        end
    end

    // results; done pulses with eff_addr, cycles and length valid
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            done <= 1'b0;
            eff_addr <= RESET_ADDR;
            next_pc <= RESET_ADDR;
            cycles <= 4'h0;
            length <= 2'h0;
        end else begin
            done <= 1'b0;
            if (state == IDLE && start && !needs_ptr) begin
                done <= 1'b1;
                cycles <= req.cycles;
                length <= req.length;
                next_pc <= seq_pc;
                if (mode == MODE_STACK)
                    eff_addr <= {STACK_PAGE, stack_ptr};
                else
                    eff_addr <= req.eff_addr;
                if (mode == MODE_REL && branch_taken)
                    next_pc <= req.eff_addr;
            end else if (state == PTR_HI) begin
                done <= 1'b1;
                cycles <= req.cycles;
                length <= req.length;
                next_pc <= seq_pc;
                if (mode_q == MODE_ZP_IND_Y)
                    eff_addr <= ptr_sum;
                else
                    eff_addr <= ptr_full;
                if (mode_q == MODE_ABS_IND || mode_q == MODE_ABS_IDX_IND)
                    next_pc <= ptr_full;
            end
        end
    end

    // handshake: busy while a pointer walk runs
    assign busy = (state != IDLE);
endmodule

// ===== logic/addr_mode_pkg.sv
package addr_mode_pkg;
    // addressing modes handled by the unit
    typedef enum logic [4:0] {
        MODE_ABS, MODE_ABS_IDX_IND, MODE_ABS_X, MODE_ABS_Y, MODE_ABS_IND,
        MODE_ACC, MODE_IMM, MODE_IMPL, MODE_REL, MODE_STACK, MODE_ZP,
        MODE_ZP_X_IND, MODE_ZP_X, MODE_ZP_Y, MODE_ZP_IND, MODE_ZP_IND_Y
    } addr_mode_e;

    localparam logic [7:0] STACK_PAGE = 8'h01;
    localparam logic [7:0] ZERO_PAGE = 8'h00;
    localparam logic [15:0] RESET_ADDR = 16'h0000;

    // base cycle counts per mode
    localparam logic [3:0] CYC_ABS = 4'h4;
    localparam logic [3:0] CYC_ABS_IDX_IND = 4'h6;
    localparam logic [3:0] CYC_ABS_X = 4'h4;
    localparam logic [3:0] CYC_ABS_Y = 4'h4;
    localparam logic [3:0] CYC_ABS_IND = 4'h6;
    localparam logic [3:0] CYC_TWO = 4'h2;
    localparam logic [3:0] CYC_REL = 4'h2;
    localparam logic [3:0] CYC_STACK = 4'h3;
    localparam logic [3:0] CYC_ZP = 4'h3;
    localparam logic [3:0] CYC_ZP_X_IND = 4'h6;
    localparam logic [3:0] CYC_ZP_X = 4'h4;
    localparam logic [3:0] CYC_ZP_Y = 4'h4;
    localparam logic [3:0] CYC_ZP_IND = 4'h5;
    localparam logic [3:0] CYC_ZP_IND_Y = 4'h5;

    // additions
    localparam logic [3:0] CYC_PAGE_ADD = 4'h1;
    localparam logic [3:0] CYC_TAKEN_ADD = 4'h1;
    localparam logic [3:0] CYC_RMW_ADD = 4'h2;
    localparam logic [3:0] CYC_STORE_X_ADD = 4'h1;

    // program bytes per instruction
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;

    // page crossing test shared by the indexed paths
    function automatic logic page_crossed(input logic [15:0] base, input logic [15:0] sum);
        page_crossed = (base[15:8] != sum[15:8]);
    endfunction
endpackage

// ===== logic/mode_req_if.sv
`timescale 1ns/1ps
// request from the control path to the helper modules
interface mode_req_if;
    import addr_mode_pkg::*;
    addr_mode_e mode;
    logic [7:0] op_lo;
    logic [7:0] op_hi;
    logic [7:0] idx_x;
    logic [7:0] idx_y;
    logic [15:0] pc;
    logic branch_taken;
    logic rmw;
    logic store_acc;
    logic [15:0] base_addr;
    logic [15:0] eff_addr;
    logic crossed;
    logic [3:0] cycles;
    logic [1:0] length;
    modport ctrl (output mode, op_lo, op_hi, idx_x, idx_y, pc, branch_taken, rmw,
        store_acc, input base_addr, eff_addr, crossed, cycles, length);
    modport calc (input mode, op_lo, op_hi, idx_x, idx_y, pc, output base_addr,
        eff_addr, crossed);
    modport count (input mode, branch_taken, rmw, store_acc, crossed,
        output cycles, length);
endinterface

// ===== logic/addr_calc.sv
`timescale 1ns/1ps
// direct address arithmetic; for the pointer modes it gives the pointer location to read
module addr_calc (
    mode_req_if.calc req
);
    import addr_mode_pkg::*;
    logic [15:0] abs_base;
    logic [15:0] rel_off;
    assign abs_base = {req.op_hi, req.op_lo};
    assign rel_off = {{8{req.op_lo[7]}}, req.op_lo};

    always_comb begin
        req.base_addr = abs_base;
        req.eff_addr = abs_base;
        unique case (req.mode)
            MODE_REL: begin
                req.base_addr = req.pc;
                req.eff_addr = req.pc + rel_off;
            end
            MODE_ABS_X, MODE_ABS_IDX_IND: req.eff_addr = abs_base + {8'h00, req.idx_x};
            MODE_ABS_Y: req.eff_addr = abs_base + {8'h00, req.idx_y};
            MODE_ZP, MODE_ZP_IND, MODE_ZP_IND_Y: begin
                req.base_addr = {ZERO_PAGE, req.op_lo};
                req.eff_addr = {ZERO_PAGE, req.op_lo};
            end
            MODE_ZP_X, MODE_ZP_X_IND: begin
                req.base_addr = {ZERO_PAGE, req.op_lo};
                // wraps in page zero, no carry out
                req.eff_addr = {ZERO_PAGE, 8'(req.op_lo + req.idx_x)};
            end
            MODE_ZP_Y: begin
                req.base_addr = {ZERO_PAGE, req.op_lo};
                req.eff_addr = {ZERO_PAGE, 8'(req.op_lo + req.idx_y)};
            end
            default: begin
                req.base_addr = abs_base;
                req.eff_addr = abs_base;
            end
        endcase
    end
    assign req.crossed = page_crossed(req.base_addr, req.eff_addr);
endmodule

// ===== logic/cycle_count.sv
`timescale 1ns/1ps
// cycle and length table per mode with its additions
module cycle_count (
    mode_req_if.count req,
    input wire logic ptr_crossed
);
    import addr_mode_pkg::*;
    logic [3:0] base;
    logic [3:0] extra;

    always_comb begin
        base = CYC_TWO;
        req.length = LEN_ONE;
        unique case (req.mode)
            MODE_ABS: begin base = CYC_ABS; req.length = LEN_THREE; end
            MODE_ABS_IDX_IND: begin base = CYC_ABS_IDX_IND; req.length = LEN_THREE; end
            MODE_ABS_X: begin base = CYC_ABS_X; req.length = LEN_THREE; end
            MODE_ABS_Y: begin base = CYC_ABS_Y; req.length = LEN_THREE; end
            MODE_ABS_IND: begin base = CYC_ABS_IND; req.length = LEN_THREE; end
            MODE_ACC, MODE_IMPL: begin base = CYC_TWO; req.length = LEN_ONE; end
            MODE_IMM: begin base = CYC_TWO; req.length = LEN_TWO; end
            MODE_REL: begin base = CYC_REL; req.length = LEN_TWO; end
            MODE_STACK: begin base = CYC_STACK; req.length = LEN_ONE; end
            MODE_ZP: begin base = CYC_ZP; req.length = LEN_TWO; end
            MODE_ZP_X_IND: begin base = CYC_ZP_X_IND; req.length = LEN_TWO; end
            MODE_ZP_X: begin base = CYC_ZP_X; req.length = LEN_TWO; end
            MODE_ZP_Y: begin base = CYC_ZP_Y; req.length = LEN_TWO; end
            MODE_ZP_IND: begin base = CYC_ZP_IND; req.length = LEN_TWO; end
            MODE_ZP_IND_Y: begin base = CYC_ZP_IND_Y; req.length = LEN_TWO; end
            default: begin base = CYC_TWO; req.length = LEN_ONE; end
        endcase
    end

    // additions; the store of the accumulator with x pays always
    always_comb begin
        extra = 4'h0;
        unique case (req.mode)
            MODE_ABS_X: begin
                if (req.store_acc)
                    extra = CYC_STORE_X_ADD;
                else if (req.crossed && !req.rmw)
                    extra = CYC_PAGE_ADD;
                if (req.rmw)
                    extra = 4'(extra + CYC_RMW_ADD);
            end
            MODE_ABS: extra = req.rmw ? CYC_RMW_ADD : 4'h0;
            MODE_ZP, MODE_ZP_X: extra = req.rmw ? CYC_RMW_ADD : 4'h0;
            MODE_ABS_Y: extra = req.crossed ? CYC_PAGE_ADD : 4'h0;
            MODE_ZP_IND_Y: extra = ptr_crossed ? CYC_PAGE_ADD : 4'h0;
            MODE_REL: begin
                if (req.branch_taken) begin
                    extra = CYC_TAKEN_ADD;
                    if (req.crossed)
                        extra = 4'(extra + CYC_PAGE_ADD);
                end
            end
            default: extra = 4'h0;
        endcase
    end
    assign req.cycles = 4'(base + extra);
endmodule

// ===== testbench/mem_model.sv
`timescale 1ns/1ps
// combinational memory; each byte is a fixed pattern of its address
module mem_model (
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata
);
    // unselected bus shows the uninverted byte and a read the inverted one, so a late sample cannot pass
    assign mem_rdata = mem_rd ? ~mem_addr[7:0] ^ mem_addr[15:8] : mem_addr[7:0] ^ mem_addr[15:8];
endmodule

// ===== testbench/addr_mode_monitor.sv
`timescale 1ns/1ps
module addr_mode_monitor (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire addr_mode_pkg::addr_mode_e mode,
    input wire logic [7:0] op_lo,
    input wire logic [7:0] op_hi,
    input wire logic [7:0] idx_x,
    input wire logic [7:0] stack_ptr,
    input wire logic [7:0] pc_low_byte,
    input wire logic [7:0] pc_high_byte,
    input wire logic branch_taken,
    input wire logic store_accumulator,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic busy,
    input wire logic done,
    input wire logic [15:0] eff_addr,
    input wire logic [15:0] next_pc,
    input wire logic [3:0] cycles
);
    import addr_mode_pkg::*;
    // inputs may change in the done cycle, so results are tied to the prior edge
    logic [15:0] pcv;
    logic [15:0] off;
    assign pcv = {pc_high_byte, pc_low_byte};
    assign off = {{8{op_lo[7]}}, op_lo};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    zp_direct_a: assert property (done && $past(mode) == MODE_ZP
        |-> eff_addr == {8'h00, $past(op_lo)}) else $error("zero page address");
    zp_x_a: assert property (done && $past(mode) == MODE_ZP_X
        |-> eff_addr == {8'h00, $past(op_lo) + $past(idx_x)}) else $error("zp x address");
    stack_page_a: assert property (done && $past(mode) == MODE_STACK
        |-> eff_addr == {8'h01, $past(stack_ptr)}) else $error("stack address");
    abs_x_a: assert property (done && $past(mode) == MODE_ABS_X
        |-> eff_addr == {$past(op_hi), $past(op_lo)} + {8'h00, $past(idx_x)})
        else $error("abs x address");
    branch_dest_a: assert property (done && $past(mode) == MODE_REL
        && $past(branch_taken) |-> next_pc == $past(pcv) + $past(off))
        else $error("branch target");
    branch_seq_a: assert property (done && $past(mode) == MODE_REL
        && !$past(branch_taken) |-> next_pc == $past(pcv) + 16'h0002)
        else $error("branch fallthrough");
    ptr_walk_a: assert property (start && !busy && mode == MODE_ZP_IND
        |=> mem_rd && mem_addr == {8'h00, op_lo}
        ##1 mem_rd && mem_addr == {8'h00, op_lo + 8'h01} ##1 done) else $error("pointer walk");
    rel_cycles_a: assert property (done && $past(mode) == MODE_REL
        |-> cycles == (!$past(branch_taken) ? 4'h2 : next_pc[15:8] != $past(pc_high_byte)
        ? 4'h4 : 4'h3)) else $error("branch cycles");
    store_x_a: assert property (done && $past(mode) == MODE_ABS_X
        && $past(store_accumulator) |-> cycles == 4'h5) else $error("store x cycles");
    cover property (done && $past(mode) == MODE_REL && $past(branch_taken));
    cover property (done && $past(mode) == MODE_ZP_IND_Y);
    cover property (start && !busy && mode == MODE_ABS_IDX_IND);
endmodule
bind cpu_address_mode_unit addr_mode_monitor mon_u (.ref_clk, .arst_n, .start, .mode,
    .op_lo, .op_hi, .idx_x, .stack_ptr, .pc_low_byte, .pc_high_byte, .branch_taken,
    .store_accumulator, .mem_rd, .mem_addr, .busy, .done, .eff_addr, .next_pc, .cycles);

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import addr_mode_pkg::*;
    logic ref_clk, arst_n, start, branch_taken, rmw, store_accumulator, mem_rd, busy, done;
    addr_mode_e mode;
    logic [7:0] op_lo, op_hi, idx_x, idx_y, stack_ptr, pc_low_byte, pc_high_byte, mem_rdata;
    logic [15:0] mem_addr, eff_addr, next_pc, cyc, len;
    logic [3:0] cycles;
    logic [1:0] length;
    int fail_count = 0;
    int total_checks = 0;
    assign cyc = {12'h000, cycles};
    assign len = {14'h0000, length};
    cpu_address_mode_unit dut_u (.ref_clk, .arst_n, .start, .mode, .op_lo, .op_hi, .idx_x,
        .idx_y, .stack_ptr, .pc_low_byte, .pc_high_byte, .branch_taken, .rmw,
        .store_accumulator, .mem_rdata, .mem_addr, .mem_rd, .busy, .done, .eff_addr,
        .next_pc, .cycles, .length);
    mem_model mem_u (.mem_addr, .mem_rd, .mem_rdata);
    // 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // pointer as memory returns it, low byte from lo_a
    function automatic logic [15:0] ptr(input logic [15:0] lo_a, input logic [15:0] hi_a);
        return {~hi_a[7:0] ^ hi_a[15:8], ~lo_a[7:0] ^ lo_a[15:8]};
    endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // waits a falling edge first, so start never drops and rises in one time step
    task automatic go(input addr_mode_e m, input logic [7:0] lo, input logic [7:0] hi,
        input logic [3:0] lat);
        logic [3:0] n;
        @(negedge ref_clk);
        mode = m;
        op_lo = lo;
        op_hi = hi;
        start = 1'b1;
        n = 4'h0;
        do begin
            @(negedge ref_clk);
            start = 1'b0;
            n++;
            if (n == 4'h1)
                chk({15'h0000, busy}, {15'h0000, lat != 4'h1});
        end while (done !== 1'b1 && n < 4'h8);
        chk({12'h000, n}, {12'h000, lat});
        if (done !== 1'b1) complete_run();
    endtask
    task automatic direct_modes;
        idx_x = 8'h20;
        idx_y = 8'h30;
        stack_ptr = 8'hFF;
        go(MODE_ZP, 8'h80, 8'h00, 4'h1);
        chk(eff_addr, 16'h0080);
        go(MODE_ZP_X, 8'hF0, 8'h00, 4'h1);
        chk(eff_addr, 16'h0010);
        go(MODE_ZP_Y, 8'hF0, 8'h00, 4'h1);
        chk(eff_addr, 16'h0020);
        go(MODE_STACK, 8'h00, 8'h00, 4'h1);
        chk(eff_addr, 16'h01FF);
        stack_ptr = 8'h00;
        go(MODE_STACK, 8'hAA, 8'h55, 4'h1);
        chk(eff_addr, 16'h0100);
        go(MODE_ABS_X, 8'hF0, 8'h12, 4'h1);
        chk(eff_addr, 16'h1310);
        chk(cyc, 16'h0005);
        $display("direct modes finished");
    endtask
    task automatic cycle_additions;
        go(MODE_ABS_X, 8'h10, 8'h12, 4'h1);
        chk(cyc, 16'h0004);
        store_accumulator = 1'b1;
        go(MODE_ABS_X, 8'h10, 8'h12, 4'h1);
        chk(cyc, 16'h0005);
        go(MODE_ABS_X, 8'hF0, 8'h12, 4'h1);
        chk(cyc, 16'h0005);
        store_accumulator = 1'b0;
        rmw = 1'b1;
        go(MODE_ABS_X, 8'h10, 8'h12, 4'h1);
        chk(cyc, 16'h0006);
        go(MODE_ZP, 8'h10, 8'h00, 4'h1);
        chk(cyc, 16'h0005);
        rmw = 1'b0;
        go(MODE_ABS_Y, 8'hF0, 8'h12, 4'h1);
        chk(eff_addr, 16'h1320);
        chk(cyc, 16'h0005);
        go(MODE_ABS_Y, 8'h00, 8'h12, 4'h1);
        chk(cyc, 16'h0004);
        $display("cycle additions finished");
    endtask
    task automatic branches;
        pc_high_byte = 8'h10;
        pc_low_byte = 8'h00;
        branch_taken = 1'b1;
        go(MODE_REL, 8'h80, 8'h00, 4'h1);
        chk(next_pc, 16'h0F80);
        chk(cyc, 16'h0004);
        go(MODE_REL, 8'h10, 8'h00, 4'h1);
        chk(next_pc, 16'h1010);
        chk(cyc, 16'h0003);
        branch_taken = 1'b0;
        go(MODE_REL, 8'h10, 8'h00, 4'h1);
        chk(next_pc, 16'h1002);
        chk(cyc, 16'h0002);
        chk(len, 16'h0002);
        $display("branches finished");
    endtask
    // modes with no pointer and no index; next_pc is the sequential address
    task automatic plain_modes;
        pc_high_byte = 8'h20;
        pc_low_byte = 8'hFE;
        rmw = 1'b1;
        go(MODE_ABS, 8'h34, 8'h12, 4'h1);
        chk(eff_addr, 16'h1234);
        chk(cyc, 16'h0006);
        chk(next_pc, 16'h2101);
        go(MODE_ACC, 8'h00, 8'h00, 4'h1);
        chk(cyc, 16'h0002);
        chk(next_pc, 16'h20FF);
        rmw = 1'b0;
        go(MODE_ABS, 8'h34, 8'h12, 4'h1);
        chk(cyc, 16'h0004);
        go(MODE_IMM, 8'h55, 8'h00, 4'h1);
        chk(len, 16'h0002);
        chk(next_pc, 16'h2100);
        go(MODE_IMPL, 8'h00, 8'h00, 4'h1);
        chk(cyc, 16'h0002);
        chk(next_pc, 16'h20FF);
        $display("plain modes finished");
    endtask
    task automatic pointer_modes;
        idx_x = 8'h0F;
        idx_y = 8'h50;
        go(MODE_ZP_IND, 8'hFF, 8'h00, 4'h3);
        chk(eff_addr, ptr(16'h00FF, 16'h0000));
        chk(cyc, 16'h0005);
        chk(len, 16'h0002);
        go(MODE_ZP_X_IND, 8'hF0, 8'h00, 4'h3);
        chk(eff_addr, ptr(16'h00FF, 16'h0000));
        chk(cyc, 16'h0006);
        chk(len, 16'h0002);
        go(MODE_ZP_IND_Y, 8'h40, 8'h00, 4'h3);
        chk(eff_addr, ptr(16'h0040, 16'h0041) + 16'h0050);
        chk(cyc, 16'h0006);
        go(MODE_ZP_IND_Y, 8'h80, 8'h00, 4'h3);
        chk(eff_addr, ptr(16'h0080, 16'h0081) + 16'h0050);
        chk(cyc, 16'h0005);
        go(MODE_ABS_IND, 8'hFF, 8'h12, 4'h3);
        chk(next_pc, ptr(16'h12FF, 16'h1300));
        chk(cyc, 16'h0006);
        chk(len, 16'h0003);
        go(MODE_ABS_IDX_IND, 8'hF8, 8'h12, 4'h3);
        chk(next_pc, ptr(16'h1307, 16'h1308));
        chk(cyc, 16'h0006);
        chk(len, 16'h0003);
        $display("pointer modes finished");
    endtask
    // start held high with another mode while busy; the walk must ignore it
    task automatic refused_start;
        logic [3:0] n;
        @(negedge ref_clk);
        mode = MODE_ZP_IND;
        op_lo = 8'h40;
        start = 1'b1;
        @(negedge ref_clk);
        mode = MODE_ABS;
        n = 4'h1;
        do begin
            @(negedge ref_clk);
            n++;
        end while (done !== 1'b1 && n < 4'h8);
        start = 1'b0;
        chk({12'h000, n}, 16'h0003);
        chk(eff_addr, ptr(16'h0040, 16'h0041));
        chk(cyc, 16'h0005);
        chk(len, 16'h0002);
        if (done !== 1'b1) complete_run();
        $display("refused start finished");
    endtask
    // reset lands in the middle of a pointer walk, then a fresh request
    task automatic reset_mid_walk;
        @(negedge ref_clk);
        mode = MODE_ZP_IND;
        op_lo = 8'h40;
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        arst_n = 1'b0;
        @(negedge ref_clk);
        chk({13'h0000, busy, done, mem_rd}, 16'h0000);
        chk(eff_addr | next_pc | mem_addr, 16'h0000);
        arst_n = 1'b1;
        go(MODE_ZP, 8'h80, 8'h00, 4'h1);
        chk(eff_addr, 16'h0080);
        $display("reset in walk finished");
    endtask
    // reset, then every scenario back to back
    initial begin
        arst_n = 1'b0;
        start = 1'b0;
        mode = MODE_ZP;
        op_lo = 8'h00;
        op_hi = 8'h00;
        idx_x = 8'h00;
        idx_y = 8'h00;
        stack_ptr = 8'h00;
        pc_low_byte = 8'h00;
        pc_high_byte = 8'h00;
        branch_taken = 1'b0;
        rmw = 1'b0;
        store_accumulator = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk(eff_addr | next_pc, 16'h0000);
        chk({10'h000, cycles, length}, 16'h0000);
        arst_n = 1'b1;
        @(negedge ref_clk);
        direct_modes();
        cycle_additions();
        branches();
        plain_modes();
        pointer_modes();
        refused_start();
        reset_mid_walk();
        complete_run();
    end
endmodule
